// [logic/flc_pkg.sv]
// Package for the flash level control register block.
// Holds the register address, reset value, field layout, timing
// constants, the flash current tables and the shared carrier types.
package flc_pkg;

    // ------------------------------------------------------------
    // Register map and field layout
    // ------------------------------------------------------------
    localparam logic [7:0] FLC_REG_ADDR    = 8'h02;
    localparam logic [7:0] FLC_RESET_VAL   = 8'h03;
    localparam logic [7:0] FLC_UNMAPPED    = 8'h00;
    localparam int         FLC_FORCE_BIT   = 7;
    localparam int         FLC_MODE_HI     = 6;
    localparam int         FLC_MODE_LO     = 5;
    localparam int         FLC_OUTER_HI    = 4;
    localparam int         FLC_OUTER_LO    = 3;
    localparam int         FLC_CENTER_HI   = 2;
    localparam int         FLC_CENTER_LO   = 0;
    localparam logic [6:0] FLC_SLAVE_ADDR  = 7'h33; // Arbitrary default

    // ------------------------------------------------------------
    // Timing: torch safety timeout at the 20 MHz system clock
    // ------------------------------------------------------------
    localparam int unsigned FLC_CLK_HZ       = 20_000_000;
    localparam int unsigned FLC_TIMEOUT_MS   = 11_200;
    localparam int unsigned FLC_TIMEOUT_CYC  =
        FLC_TIMEOUT_MS * (FLC_CLK_HZ / 1000);
    localparam int          FLC_TMR_W        = 28;

    // ------------------------------------------------------------
    // Mode encodings and bus state machine
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FLC_MODE_SHUTDOWN = 2'b00,
        FLC_MODE_TORCH    = 2'b01,
        FLC_MODE_FLASH    = 2'b10,
        FLC_MODE_VSOURCE  = 2'b11
    } flc_mode_t;

    typedef enum logic [2:0] {
        FLC_ST_IDLE  = 3'b000,
        FLC_ST_ADDR  = 3'b001,
        FLC_ST_REG   = 3'b010,
        FLC_ST_WDATA = 3'b011,
        FLC_ST_ACK   = 3'b100,
        FLC_ST_RDATA = 3'b101,
        FLC_ST_RACK  = 3'b110
    } flc_state_t;

    // ------------------------------------------------------------
    // Flash current tables in mA, [variant][high current][code]
    // ------------------------------------------------------------
    typedef logic [10:0] flc_ma_t;
    localparam flc_ma_t FLC_OUTER_MA [2][2][4] = '{
        '{'{11'h0FA, 11'h12C, 11'h15E, 11'h15E},
          '{11'h258, 11'h2BC, 11'h320, 11'h39D}},
        '{'{11'h113, 11'h14F, 11'h181, 11'h181},
          '{11'h299, 11'h307, 11'h37A, 11'h401}}};
    localparam flc_ma_t FLC_CENTER_MA [2][2][8] = '{
        '{'{11'h113, 11'h12C, 11'h15E, 11'h1C2,
            11'h226, 11'h258, 11'h2BC, 11'h2BC},
          '{11'h28A, 11'h2BC, 11'h339, 11'h41A,
            11'h514, 11'h578, 11'h640, 11'h640}},
        '{'{11'h131, 11'h14F, 11'h181, 11'h1F4,
            11'h262, 11'h299, 11'h307, 11'h307},
          '{11'h2D0, 11'h307, 11'h393, 11'h48D,
            11'h5AA, 11'h60E, 11'h6EF, 11'h6EF}}};

    // Drive bundle toward the converter and current sinks
    typedef struct packed {
        logic [1:0] op_mode;
        logic       cv_force;
        logic       volt_reg;
        flc_ma_t    outer_ma;
        flc_ma_t    center_ma;
    } flc_drive_t;

endpackage

// [logic/flc_top.sv]
// Flash level control register with its serial bus slave.
// Assumes a 20 MHz clock, open-drain bus pins resolved outside and
// a torch level register elsewhere that takes the mirrored mode.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// (RQ1) Force bit one makes constant voltage source
// (RQ2) Force bit reads back the mode pin
// (RQ3) Mode field decodes shutdown, torch, flash, voltage
// (RQ4) Unrefreshed mode shuts down after timeout
// (RQ5) Mode writes are mirrored to torch register
// (RQ6) Variant one outer flash current table
// (RQ7) Variant two outer flash current table
// (RQ8) Variant one centre flash current table
// (RQ9) Variant two centre flash current table
// (RQ10) Write applies at falling edge of acknowledge
// (RQ11) Zero torch levels select voltage regulation
// (RQ12) Unlisted codes kept, drive highest listed level
// (RQ13) Variant set at build, same layout
module flc_top
    import flc_pkg::*;
#(
    parameter int          VARIANT     = 0,
    parameter int unsigned TIMEOUT_CYC = FLC_TIMEOUT_CYC,
    parameter logic [6:0]  SLAVE_ADDR  = FLC_SLAVE_ADDR
)(
    // Clock, reset, enable
    input  wire logic       mclk_in,
    input  wire logic       nrst_in,
    input  wire logic       ce_in,
    // Serial bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    // Device pins and neighbour status
    input  wire logic       voltage_mode_pin_in,
    input  wire logic       high_current_select_in,
    input  wire logic       torch_levels_zero_in,
    // Drive and mirror outputs
    output flc_drive_t      drive_out,
    output logic            mode_mirror_wr_out,
    output logic [1:0]      mode_mirror_out
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (VARIANT < 0 || VARIANT > 1)
        $error("VARIANT must be 0 or 1");
    if (TIMEOUT_CYC < 1 || TIMEOUT_CYC >= (64'd1 << FLC_TMR_W))
        $error("TIMEOUT_CYC out of range");

    localparam logic [FLC_TMR_W-1:0] TMO_LAST =
        FLC_TMR_W'(TIMEOUT_CYC - 1);

    // ------------------------------------------------------------
    // Pin synchronisers: bit0 scl, bit1 sda, bit2 vmode, bit3 hcs
    // ------------------------------------------------------------
    logic [3:0] s1_ff, s2_ff, s3_ff, flt_ff, fltd_ff;
    logic [3:0] nxt_flt;

    // Level changes once the second and third stages agree
    always_comb
    begin
        nxt_flt = ((s2_ff ~^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & flt_ff);
    end

    always_ff @(posedge mclk_in)
    begin
        if (!nrst_in)
        begin
            s1_ff   <= 4'h3;
            s2_ff   <= 4'h3;
            s3_ff   <= 4'h3;
            flt_ff  <= 4'h3;
            fltd_ff <= 4'h3;
        end
        else if (ce_in)
        begin
            s1_ff   <= {high_current_select_in, voltage_mode_pin_in,
                        sda_in, scl_in};
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            flt_ff  <= nxt_flt;
            fltd_ff <= flt_ff;
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop, sda_lvl;
    assign sda_lvl   = flt_ff[1];
    assign scl_rise  = flt_ff[0] & ~fltd_ff[0];
    assign scl_fall  = ~flt_ff[0] & fltd_ff[0];
    assign bus_start = flt_ff[0] & fltd_ff[0] & ~flt_ff[1] & fltd_ff[1];
    assign bus_stop  = flt_ff[0] & fltd_ff[0] & flt_ff[1] & ~fltd_ff[1];

    // ------------------------------------------------------------
    // Bus slave state machine
    // ------------------------------------------------------------
    flc_state_t st_ff, nxt_st, after_ff, nxt_after;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [7:0] sh_ff, nxt_sh, radr_ff, nxt_radr;
    logic       oe_ff, nxt_oe, wpend_ff, nxt_wpend, wr_ff, nxt_wr;
    logic [7:0] flc_ff, nxt_flc, rd_val;

    // Read value: force bit shows the pin, unmapped reads zero
    assign rd_val = (radr_ff == FLC_REG_ADDR) ?
                    {flt_ff[2], flc_ff[6:0]} : FLC_UNMAPPED; // RQ2

    // Byte reception, acknowledge and read-out sequencing
    always_comb
    begin
        nxt_st    = st_ff;
        nxt_after = after_ff;
        nxt_cnt   = cnt_ff;
        nxt_sh    = sh_ff;
        nxt_radr  = radr_ff;
        nxt_oe    = oe_ff;
        nxt_wpend = wpend_ff;
        nxt_wr    = 1'b0;
        if (bus_start)
        begin
            nxt_st    = FLC_ST_ADDR;
            nxt_cnt   = 4'h0;
            nxt_oe    = 1'b0;
            nxt_wpend = 1'b0;
        end
        else if (bus_stop)
        begin
            nxt_st = FLC_ST_IDLE;
            nxt_oe = 1'b0;
        end
        else
        begin
            case (st_ff)
                FLC_ST_ADDR, FLC_ST_REG, FLC_ST_WDATA:
                begin
                    if (scl_rise)
                    begin
                        nxt_sh  = {sh_ff[6:0], sda_lvl};
                        nxt_cnt = cnt_ff + 4'h1;
                    end
                    else if (scl_fall && cnt_ff == 4'h8)
                    begin
                        nxt_cnt = 4'h0;
                        nxt_oe  = 1'b1;
                        nxt_st  = FLC_ST_ACK;
                        if (st_ff == FLC_ST_ADDR)
                        begin
                            nxt_after = sh_ff[0] ? FLC_ST_RDATA
                                                 : FLC_ST_REG;
                            if (sh_ff[7:1] != SLAVE_ADDR)
                            begin
                                nxt_oe = 1'b0;
                                nxt_st = FLC_ST_IDLE;
                            end
                        end
                        else if (st_ff == FLC_ST_REG)
                        begin
                            nxt_radr  = sh_ff;
                            nxt_after = FLC_ST_WDATA;
                        end
                        else
                        begin
                            nxt_wpend = 1'b1;
                            nxt_after = FLC_ST_WDATA;
                        end
                    end
                end
                FLC_ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        nxt_oe    = 1'b0;
                        nxt_st    = after_ff;
                        nxt_wr    = wpend_ff; // RQ10
                        nxt_wpend = 1'b0;
                        if (after_ff == FLC_ST_RDATA)
                        begin
                            nxt_sh  = rd_val;
                            nxt_oe  = ~rd_val[7];
                            nxt_cnt = 4'h1;
                        end
                    end
                end
                FLC_ST_RDATA:
                begin
                    if (scl_fall)
                    begin
                        if (cnt_ff == 4'h8)
                        begin
                            nxt_oe  = 1'b0;
                            nxt_cnt = 4'h0;
                            nxt_st  = FLC_ST_RACK;
                        end
                        else
                        begin
                            nxt_oe  = ~sh_ff[6];
                            nxt_sh  = {sh_ff[6:0], 1'b0};
                            nxt_cnt = cnt_ff + 4'h1;
                        end
                    end
                end
                FLC_ST_RACK:
                begin
                    if (scl_rise)
                    begin
                        nxt_after = FLC_ST_RDATA;
                        nxt_st    = sda_lvl ? FLC_ST_IDLE : FLC_ST_ACK;
                    end
                end
                default:
                begin
                    nxt_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!nrst_in)
        begin
            st_ff    <= FLC_ST_IDLE;
            after_ff <= FLC_ST_IDLE;
            cnt_ff   <= 4'h0;
            sh_ff    <= 8'h00;
            radr_ff  <= 8'h00;
            oe_ff    <= 1'b0;
            wpend_ff <= 1'b0;
            wr_ff    <= 1'b0;
        end
        else if (ce_in)
        begin
            st_ff    <= nxt_st;
            after_ff <= nxt_after;
            cnt_ff   <= nxt_cnt;
            sh_ff    <= nxt_sh;
            radr_ff  <= nxt_radr;
            oe_ff    <= nxt_oe;
            wpend_ff <= nxt_wpend;
            wr_ff    <= nxt_wr;
        end
    end

    // ------------------------------------------------------------
    // Register, safety timer and drive decode
    // ------------------------------------------------------------
    logic [FLC_TMR_W-1:0] tmr_ff, nxt_tmr;
    flc_drive_t           drv_ff, nxt_drv;
    logic                 mwr_ff, nxt_mwr;
    logic [1:0]           mmode_ff, nxt_mmode;
    logic                 reg_wr, hcs;
    flc_mode_t            mode;

    assign reg_wr = wr_ff && (radr_ff == FLC_REG_ADDR);
    assign hcs    = flt_ff[3];
    assign mode   = flc_mode_t'(flc_ff[FLC_MODE_HI:FLC_MODE_LO]);

    // Stores writes, runs the timeout and looks up the currents
    always_comb
    begin
        nxt_flc   = flc_ff;
        nxt_tmr   = tmr_ff;
        nxt_mwr   = 1'b0;
        nxt_mmode = mmode_ff;
        if (reg_wr)
        begin
            nxt_flc   = sh_ff; // RQ12 RQ13
            nxt_tmr   = '0;    // RQ4
            nxt_mwr   = 1'b1;  // RQ5
            nxt_mmode = sh_ff[FLC_MODE_HI:FLC_MODE_LO]; // RQ5
        end
        else if (mode != FLC_MODE_SHUTDOWN)
        begin
            if (tmr_ff == TMO_LAST)
            begin
                nxt_flc[FLC_MODE_HI:FLC_MODE_LO] = FLC_MODE_SHUTDOWN; // RQ4
                nxt_tmr = '0;
            end
            else
            begin
                nxt_tmr = tmr_ff + 1'b1; // RQ4
            end
        end
        nxt_drv.op_mode  = mode; // RQ3
        nxt_drv.cv_force = flc_ff[FLC_FORCE_BIT] | flt_ff[2]; // RQ1
        nxt_drv.volt_reg = torch_levels_zero_in; // RQ11
        nxt_drv.outer_ma = FLC_OUTER_MA[VARIANT][hcs]
            [flc_ff[FLC_OUTER_HI:FLC_OUTER_LO]]; // RQ6 RQ7 RQ12
        nxt_drv.center_ma = FLC_CENTER_MA[VARIANT][hcs]
            [flc_ff[FLC_CENTER_HI:FLC_CENTER_LO]]; // RQ8 RQ9 RQ12
    end

    always_ff @(posedge mclk_in)
    begin
        if (!nrst_in)
        begin
            flc_ff   <= FLC_RESET_VAL;
            tmr_ff   <= '0;
            drv_ff   <= '0;
            mwr_ff   <= 1'b0;
            mmode_ff <= 2'b00;
        end
        else if (ce_in)
        begin
            flc_ff   <= nxt_flc;
            tmr_ff   <= nxt_tmr;
            drv_ff   <= nxt_drv;
            mwr_ff   <= nxt_mwr;
            mmode_ff <= nxt_mmode;
        end
    end

    // Outputs straight from flip-flops; sda only ever pulls low
    assign sda_out            = 1'b0;
    assign sda_oe_out         = oe_ff;
    assign drive_out          = drv_ff;
    assign mode_mirror_wr_out = mwr_ff;
    assign mode_mirror_out    = mmode_ff;

endmodule // flc_top

`default_nettype wire

// [verif/flc_host.sv]
// Serial bus master standing in for the host processor.
// Assumes an open-drain data wire with a pull-up resolved outside.
`timescale 1ns/1ns
`default_nettype none
module flc_host (
    // Clock and resolved data wire
    input  wire logic mclk_in,
    input  wire logic sda_in,
    // Bus lines, high means released
    output logic      scl_out,
    output logic      sda_out
);
    localparam int HALF = 6;

    // Bus idles released
    initial
    begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
    endtask

    // Data moves only while the clock line is low
    task automatic put_bit(input logic b, output logic got);
        sda_out <= b;
        tick(HALF);
        scl_out <= 1'b1;
        tick(HALF);
        got = sda_in;
        scl_out <= 1'b0;
        tick(2);
    endtask

    task automatic start_c();
        sda_out <= 1'b1;
        tick(HALF);
        scl_out <= 1'b1;
        tick(HALF);
        sda_out <= 1'b0;
        tick(HALF);
        scl_out <= 1'b0;
        tick(2);
    endtask

    task automatic stop_c();
        sda_out <= 1'b0;
        tick(HALF);
        scl_out <= 1'b1;
        tick(HALF);
        sda_out <= 1'b1;
        tick(HALF);
    endtask

    // Byte MSB first, then a released ninth bit for the answer
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                        output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--)
        begin
            put_bit(tx[i], b);
            rx[i] = b;
        end
        put_bit(1'b1, ack);
    endtask

    task automatic wr(input logic [6:0] dev, input logic [7:0] adr,
                      input logic [7:0] dat, output logic ok);
        logic [7:0] rx;
        logic       a, b, c;
        start_c();
        xfer({dev, 1'b0}, rx, a);
        xfer(adr, rx, b);
        xfer(dat, rx, c);
        stop_c();
        ok = !(a | b | c);
    endtask

    // Read ends with a master refusal of the data byte
    task automatic rd(input logic [6:0] dev, input logic [7:0] adr,
                      output logic [7:0] dat, output logic ok);
        logic [7:0] rx;
        logic       a, b, c, n;
        start_c();
        xfer({dev, 1'b0}, rx, a);
        xfer(adr, rx, b);
        start_c();
        xfer({dev, 1'b1}, rx, c);
        xfer(8'hFF, dat, n);
        stop_c();
        ok = !(a | b | c);
    endtask
endmodule // flc_host
`default_nettype wire

// [verif/flc_top_assertions.sv]
// Port checker for the flash level control register block.
// Assumes bus clock phases of six system clocks or more.
`timescale 1ns/1ns
`default_nettype none
module flc_top_assertions
    import flc_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = FLC_TIMEOUT_CYC
)(
    // Clock and reset
    input wire logic       mclk_in,
    input wire logic       nrst_in,
    // Watched outputs and their causes
    input wire logic       scl_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_out,
    input wire logic       torch_levels_zero_in,
    input wire flc_drive_t drive_out,
    input wire logic       mode_mirror_wr_out,
    input wire logic [1:0] mode_mirror_out
);
    logic [31:0] live_ff;
    logic [31:0] nxt_live;

    default clocking dc @(posedge mclk_in);
    endclocking
    default disable iff (!nrst_in);

    // Acknowledge pull off now but still on two or three cycles back
    sequence ack_dropped;
        !sda_oe_out && ($past(sda_oe_out, 2) || $past(sda_oe_out, 3));
    endsequence

    // Cycles spent in a live mode since the last write
    always_comb
    begin
        nxt_live = live_ff + 32'h0000_0001;
        if (mode_mirror_wr_out || drive_out.op_mode == FLC_MODE_SHUTDOWN)
            nxt_live = 32'h0000_0000;
    end

    // Register the live counter
    always_ff @(posedge mclk_in)
    begin
        if (!nrst_in)
            live_ff <= 32'h0000_0000;
        else
            live_ff <= nxt_live;
    end

    // Data pull only moves while the bus clock is low
    sda_low_a: assert property (
        sda_out == 1'b0 &&
        (!$changed(sda_oe_out) || $past(scl_in, 2) == 1'b0))
        else $error("data pin moved while bus clock high");
    pulse_one_a: assert property (
        mode_mirror_wr_out |=> !mode_mirror_wr_out)
        else $error("mirror pulse too long");
    mirror_mode_a: assert property (
        mode_mirror_wr_out |=> drive_out.op_mode == mode_mirror_out)
        else $error("drive mode differs from mirror");
    volt_reg_a: assert property (
        $past(nrst_in) && $past(nrst_in, 2)
        |-> drive_out.volt_reg == $past(torch_levels_zero_in))
        else $error("regulation flag wrong");
    oe_hold_a: assert property (
        $rose(sda_oe_out) |-> sda_oe_out [*4])
        else $error("data pull released early");
    ack_write_a: assert property (
        mode_mirror_wr_out |-> ack_dropped)
        else $error("write not at end of acknowledge");
    safety_timer_a: assert property (
        live_ff <= TIMEOUT_CYC + 32'h0000_0004)
        else $error("mode outlived safety timer");
    mode_cause_a: assert property (
        $changed(drive_out.op_mode) |-> $past(mode_mirror_wr_out)
        || drive_out.op_mode == FLC_MODE_SHUTDOWN)
        else $error("mode changed without write");
endmodule // flc_top_assertions

bind flc_top flc_top_assertions #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
) i_flc_top_assertions (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .scl_in(scl_in),
    .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .torch_levels_zero_in(torch_levels_zero_in),
    .drive_out(drive_out), .mode_mirror_wr_out(mode_mirror_wr_out),
    .mode_mirror_out(mode_mirror_out)
);
`default_nettype wire

// [verif/test_flash_level_control_register.sv]
// Self-checking bench for the flash level control register.
// Assumes both variants on one bus and a shortened safety timeout.
`timescale 1ns/1ns
`default_nettype none
module test_flash_level_control_register
    import flc_pkg::*;
;
    localparam int unsigned TMO = 2000;
    logic       mclk_in, nrst_in, hc, pin, torch, scl, sda_host;
    logic       sda_oe, sda_drv, sda_wire, mwr;
    logic       sda_oe_b, sda_drv_b, mwr_b;
    logic [1:0] mmode, mmode_b;
    flc_drive_t drive, mexp, drive_b, mexp_b;
    flc_drive_t notes[$], notes_b[$];
    int         bad_count, samples_checked;
    flc_ma_t    outer_tab [8] = '{11'h0FA, 11'h12C, 11'h15E, 11'h15E,
        11'h258, 11'h2BC, 11'h320, 11'h39D};
    flc_ma_t    center_tab [16] = '{11'h113, 11'h12C, 11'h15E, 11'h1C2,
        11'h226, 11'h258, 11'h2BC, 11'h2BC, 11'h28A, 11'h2BC, 11'h339,
        11'h41A, 11'h514, 11'h578, 11'h640, 11'h640};
    flc_ma_t    outer_tab_b [8] = '{11'h113, 11'h14F, 11'h181, 11'h181,
        11'h299, 11'h307, 11'h37A, 11'h401};
    flc_ma_t    center_tab_b [16] = '{11'h131, 11'h14F, 11'h181, 11'h1F4,
        11'h262, 11'h299, 11'h307, 11'h307, 11'h2D0, 11'h307, 11'h393,
        11'h48D, 11'h5AA, 11'h60E, 11'h6EF, 11'h6EF};

    // Open-drain data wire with pull-up, shared by both devices
    assign sda_wire = sda_host & (sda_drv | ~sda_oe)
                    & (sda_drv_b | ~sda_oe_b);

    flc_top #(.VARIANT(0), .TIMEOUT_CYC(TMO)) i_flc_top (
        .mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(1'b1),
        .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_drv),
        .sda_oe_out(sda_oe), .voltage_mode_pin_in(pin),
        .high_current_select_in(hc), .torch_levels_zero_in(torch),
        .drive_out(drive), .mode_mirror_wr_out(mwr),
        .mode_mirror_out(mmode));
    // Second variant at the same address: same layout, so its bus
    // answers match bit for bit while its current tables differ
    flc_top #(.VARIANT(1), .TIMEOUT_CYC(TMO)) i_flc_top_b (
        .mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(1'b1),
        .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_drv_b),
        .sda_oe_out(sda_oe_b), .voltage_mode_pin_in(pin),
        .high_current_select_in(hc), .torch_levels_zero_in(torch),
        .drive_out(drive_b), .mode_mirror_wr_out(mwr_b),
        .mode_mirror_out(mmode_b));
    flc_host i_flc_host (.mclk_in(mclk_in), .sda_in(sda_wire),
        .scl_out(scl), .sda_out(sda_host));

    task automatic check(input string nm, input logic [25:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // 20 MHz clock
    initial
    begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end

    // Each write pulse takes the oldest note and checks the drive
    initial
    begin
        forever
        begin
            @(posedge mclk_in);
            #1;
            if (mwr === 1'b1)
            begin
                check("pulse b", 26'(mwr_b), 26'h1);
                @(posedge mclk_in);
                #1;
                if (notes.size() == 0 || notes_b.size() == 0)
                    check("pulse", 26'h1, 26'h0);
                else
                begin
                    mexp = notes.pop_front();
                    mexp_b = notes_b.pop_front();
                    check("drive", drive, mexp);
                    check("mirror", 26'(mmode), 26'(mexp.op_mode));
                    check("drive b", drive_b, mexp_b);
                    check("mirror b", 26'(mmode_b), 26'(mexp_b.op_mode));
                end
            end
        end
    end

    // Hang guard
    initial
    begin
        repeat (95000) @(posedge mclk_in);
        bad_count++;
        stop_test();
    end

    // Main sequence
    initial
    begin
        logic [7:0] d, rx;
        logic       ok;
        nrst_in = 1'b0;
        hc = 1'b0;
        pin = 1'b0;
        torch = 1'b0;
        bad_count = 0;
        samples_checked = 0;
        void'($urandom(78));
        repeat (12) @(posedge mclk_in);
        nrst_in <= 1'b1;
        repeat (4) @(posedge mclk_in);
        i_flc_host.rd(FLC_SLAVE_ADDR, FLC_REG_ADDR, rx, ok);
        check("reset", 26'(rx), 26'(FLC_RESET_VAL));
        // Every code under both current tables, random upper bits
        for (int i = 0; i < 64; i++)
        begin
            d = {3'($urandom), i[4:0]};
            hc <= i[5];
            pin <= 1'($urandom);
            torch <= 1'($urandom);
            repeat (8) @(posedge mclk_in);
            notes.push_back('{d[6:5], d[7] | pin, torch,
                outer_tab[{hc, d[4:3]}], center_tab[{hc, d[2:0]}]});
            notes_b.push_back('{d[6:5], d[7] | pin, torch,
                outer_tab_b[{hc, d[4:3]}], center_tab_b[{hc, d[2:0]}]});
            i_flc_host.wr(FLC_SLAVE_ADDR, FLC_REG_ADDR, d, ok);
            check("ack", 26'(ok), 26'h1);
            i_flc_host.rd(FLC_SLAVE_ADDR, FLC_REG_ADDR, rx, ok);
            check("read", 26'(rx), 26'({pin, d[6:0]}));
        end
        // Torch mode left unrefreshed lapses to shutdown
        notes.push_back('{2'b01, pin, torch, outer_tab[{hc, 2'b00}],
            center_tab[{hc, 3'b000}]});
        notes_b.push_back('{2'b01, pin, torch, outer_tab_b[{hc, 2'b00}],
            center_tab_b[{hc, 3'b000}]});
        i_flc_host.wr(FLC_SLAVE_ADDR, FLC_REG_ADDR, 8'h20, ok);
        repeat (TMO + 20) @(posedge mclk_in);
        check("lapse", 26'(drive.op_mode), 26'h0);
        check("lapse b", 26'(drive_b.op_mode), 26'h0);
        // Wrong device, unmapped register, then stored value kept
        i_flc_host.wr(7'(FLC_SLAVE_ADDR + 7'h01), FLC_REG_ADDR, 8'h60, ok);
        check("nack", 26'(ok), 26'h0);
        i_flc_host.wr(FLC_SLAVE_ADDR, FLC_UNMAPPED, 8'h60, ok);
        i_flc_host.rd(FLC_SLAVE_ADDR, FLC_UNMAPPED, rx, ok);
        check("unmapped", 26'(rx), 26'h0);
        i_flc_host.rd(FLC_SLAVE_ADDR, FLC_REG_ADDR, rx, ok);
        check("kept", 26'(rx), 26'({pin, 7'h00}));
        check("notes", 26'(notes.size()), 26'h0);
        check("notes b", 26'(notes_b.size()), 26'h0);
        stop_test();
    end
endmodule // test_flash_level_control_register
`default_nettype wire
